// file: common/ebpcp_pkg.sv
package ebpcp_pkg;
  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int LOWER_N = 5;
  localparam int CHG_LO = 4;
  localparam int CHG_N = 4;
  localparam int PULLUP_BIT = 7;
  localparam int CHANGE_FLAG_BIT = 0;
  localparam int CAPTURE_PIN = 3;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic PULLUP_DISABLE_RESET = 1'b1;
  localparam logic [4:0] ANALOG_ALL = 5'h1f;
  localparam logic [4:0] ANALOG_NONE = 5'h00;
endpackage : ebpcp_pkg

// file: verilog/ebpcp_sync.sv
`timescale 1ns/1ns
module ebpcp_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : ebpcp_sync

// file: verilog/ebpcp_change.sv
`timescale 1ns/1ns
module ebpcp_change #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins and control
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] is_input,
  input wire logic refresh,
  // result
  output logic mismatch
);
  logic [WIDTH-1:0] snap_r;
  logic [WIDTH-1:0] diff;

  always_ff @(posedge clk)
  begin
    if (reset)
      snap_r <= '0;
    else if (refresh)
      snap_r <= level;
  end

  // outputs are masked out of the compare
  assign diff = (level ^ snap_r) & is_input;
  assign mismatch = |diff;
endmodule : ebpcp_change

// file: verilog/ebpcp_port.sv
`timescale 1ns/1ns
module ebpcp_port (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration bits, caught at reset release
  input wire logic lower_pins_analog_default,
  input wire logic capture_pin_select,
  // processor access to port_pin_register
  input wire logic port_rd,
  input wire logic port_wr,
  input wire logic port_wr_is_move,
  input wire logic [7:0] port_wdata,
  output logic [7:0] port_rdata,
  // processor access to output_latch
  input wire logic latch_wr,
  output logic [7:0] latch_rdata,
  // direction_mask
  input wire logic dir_wr,
  input wire logic [7:0] dir_wdata,
  output logic [7:0] direction_mask,
  // pull-up control bit of interrupt_control_two
  input wire logic pullup_wr,
  input wire logic pullup_wdata,
  output logic pullup_disable_n,
  // analog select for lower pins from the converter
  input wire logic analog_wr,
  input wire logic [4:0] analog_wdata,
  output logic [4:0] analog_sel,
  // change flag of interrupt_control_main
  input wire logic flag_clr,
  output logic port_change_flag,
  output logic wake_req,
  // pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] pullup_en,
  // capture/compare alternate pin
  output logic capture_alt_in,
  output logic capture_alt_sel
);
  logic [7:0] output_latch_r;
  logic [7:0] dir_r;
  logic pullup_dis_r;
  logic [4:0] analog_r;
  logic flag_r;
  logic cap_sel_r;
  logic strap_done_r;
  logic [7:0] pin_sync;
  logic [7:0] port_view;
  logic mismatch;
  logic port_refresh;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  ebpcp_sync #(.WIDTH(ebpcp_pkg::PORT_W)) u_sync (
    .clk(clk),
    .reset(reset),
    .d(pin_in),
    .q(pin_sync)
  );

  // ----------------------------------------------------------------
  // output latch and direction
  // ----------------------------------------------------------------
  // a port write lands in the latch, not on the pins
  always_ff @(posedge clk)
  begin
    if (reset)
      output_latch_r <= ebpcp_pkg::LATCH_RESET;
    else if (latch_wr)
      output_latch_r <= port_wdata;
    else if (port_wr)
      output_latch_r <= port_wdata;
  end

  // every pin wakes up as an input
  always_ff @(posedge clk)
  begin
    if (reset)
      dir_r <= ebpcp_pkg::DIR_RESET;
    else if (dir_wr)
      dir_r <= dir_wdata;
  end

  // one bit serves all eight pins
  always_ff @(posedge clk)
  begin
    if (reset)
      pullup_dis_r <= ebpcp_pkg::PULLUP_DISABLE_RESET;
    else if (pullup_wr)
      pullup_dis_r <= pullup_wdata;
  end

  // ----------------------------------------------------------------
  // configuration straps
  // ----------------------------------------------------------------
  // straps sampled one edge after release, not under reset
  always_ff @(posedge clk)
  begin
    if (reset)
      strap_done_r <= 1'b0;
    else
      strap_done_r <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      analog_r <= ebpcp_pkg::ANALOG_ALL;
    else if (!strap_done_r)
      analog_r <= lower_pins_analog_default ? ebpcp_pkg::ANALOG_ALL : ebpcp_pkg::ANALOG_NONE;
    else if (analog_wr)
      analog_r <= analog_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      cap_sel_r <= 1'b1;
    else if (!strap_done_r)
      cap_sel_r <= capture_pin_select;
  end

  // ----------------------------------------------------------------
  // pin drive and read view
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < ebpcp_pkg::PORT_W; gi++)
    begin : g_pin
      assign pin_out[gi] = output_latch_r[gi];
      assign pin_oe_n[gi] = dir_r[gi];
      assign pullup_en[gi] = !pullup_dis_r && dir_r[gi];
      if (gi < ebpcp_pkg::LOWER_N)
      begin : g_lower
        // analog pins read zero in the digital view
        assign port_view[gi] = analog_r[gi] ? 1'b0 :
          (dir_r[gi] ? pin_sync[gi] : output_latch_r[gi]);
      end
      else
      begin : g_upper
        assign port_view[gi] = dir_r[gi] ? pin_sync[gi] : output_latch_r[gi];
      end
    end
  endgenerate

  // one cycle late, but never a half-settled pin
  always_ff @(posedge clk)
  begin
    if (reset)
      port_rdata <= 8'h00;
    else
      port_rdata <= port_view;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      latch_rdata <= 8'h00;
    else
      latch_rdata <= output_latch_r;
  end

  // ----------------------------------------------------------------
  // interrupt on change
  // ----------------------------------------------------------------
  // block moves into the port leave the snapshot alone
  assign port_refresh = port_rd || (port_wr && !port_wr_is_move);

  // snapshot starts at zero: a high input flags until the first read or non-move port write
  ebpcp_change #(.WIDTH(ebpcp_pkg::CHG_N)) u_change (
    .clk(clk),
    .reset(reset),
    .level(pin_sync[ebpcp_pkg::CHG_LO +: ebpcp_pkg::CHG_N]),
    .is_input(dir_r[ebpcp_pkg::CHG_LO +: ebpcp_pkg::CHG_N]),
    .refresh(port_refresh),
    .mismatch(mismatch)
  );

  // set beats clear: a live mismatch keeps the flag up
  always_ff @(posedge clk)
  begin
    if (reset)
      flag_r <= 1'b0;
    else if (mismatch)
      flag_r <= 1'b1;
    else if (flag_clr)
      flag_r <= 1'b0;
  end

  // wake is combinational so it needs no running core state
  assign wake_req = flag_r || mismatch;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign direction_mask = dir_r;
  assign pullup_disable_n = pullup_dis_r;
  assign analog_sel = analog_r;
  assign port_change_flag = flag_r;
  assign capture_alt_sel = !cap_sel_r;
  assign capture_alt_in = pin_sync[ebpcp_pkg::CAPTURE_PIN];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  pin_drive_a: assert property (@(posedge clk) disable iff (reset)
    !dir_r[0] |-> pin_out[0] == output_latch_r[0] && !pin_oe_n[0])
    else $error("output pin not driven from latch");
  pin_float_a: assert property (@(posedge clk) disable iff (reset)
    dir_r[7] |-> pin_oe_n[7])
    else $error("input pin driver enabled");
  pullup_out_a: assert property (@(posedge clk) disable iff (reset)
    (pullup_en & ~dir_r) == 8'h00)
    else $error("pull-up on output pin");
  pullup_ctl_a: assert property (@(posedge clk) disable iff (reset)
    pullup_wr && !pullup_wdata && dir_r[1] && !dir_wr |=> pullup_en[1])
    else $error("pull-up not enabled");
  pullup_reset_a: assert property (@(posedge clk)
    $fell(reset) |-> pullup_en == 8'h00)
    else $error("pull-up on after reset");
  latch_write_a: assert property (@(posedge clk) disable iff (reset)
    latch_wr |=> ##1 latch_rdata == $past(port_wdata, 2))
    else $error("latch readback wrong");
  analog_zero_a: assert property (@(posedge clk) disable iff (reset)
    analog_r[2] |=> port_rdata[2] == 1'b0)
    else $error("analog pin reads nonzero");
  flag_hold_a: assert property (@(posedge clk) disable iff (reset)
    mismatch |=> flag_r)
    else $error("flag not set on mismatch");
  snap_end_a: assert property (@(posedge clk) disable iff (reset)
    port_rd |=> !$stable(pin_sync) || !mismatch)
    else $error("read did not end mismatch");
  move_keep_a: assert property (@(posedge clk) disable iff (reset)
    port_wr && port_wr_is_move && !port_rd && !dir_wr && mismatch |=> !$stable(pin_sync) || mismatch)
    else $error("move ended mismatch");
  flag_clear_a: assert property (@(posedge clk) disable iff (reset)
    flag_r && flag_clr && !mismatch |=> !flag_r)
    else $error("flag not cleared");
  out_excluded_a: assert property (@(posedge clk) disable iff (reset)
    dir_r[7:4] == 4'h0 |-> !mismatch)
    else $error("output pin caused change");
  wake_flag_a: assert property (@(posedge clk) disable iff (reset)
    $rose(flag_r) |-> $past(wake_req) && wake_req)
    else $error("no wake with flag set");
  strap_a: assert property (@(posedge clk)
    $fell(reset) && !lower_pins_analog_default |=> analog_r == 5'h00)
    else $error("strap not applied");
  cap_pin_a: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |=> capture_alt_sel == !$past(capture_pin_select))
    else $error("capture select wrong");
  dir_reset_a: assert property (@(posedge clk)
    $fell(reset) |-> pin_oe_n == 8'hff)
    else $error("pin not input after reset");
  dir_write_a: assert property (@(posedge clk) disable iff (reset)
    dir_wr |=> direction_mask == $past(dir_wdata))
    else $error("direction write lost");
  port_write_a: assert property (@(posedge clk) disable iff (reset)
    port_wr && !latch_wr |=> output_latch_r == $past(port_wdata))
    else $error("port write missed latch");
  pullup_global_a: assert property (@(posedge clk) disable iff (reset)
    pullup_dis_r |-> pullup_en == 8'h00)
    else $error("pull-up on while disabled");
  in_read_a: assert property (@(posedge clk) disable iff (reset)
    dir_r[6] |=> port_rdata[6] == $past(pin_sync[6]))
    else $error("input pin read wrong");
  out_read_a: assert property (@(posedge clk) disable iff (reset)
    !dir_r[6] |=> port_rdata[6] == $past(output_latch_r[6]))
    else $error("output pin read wrong");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------

  flag_set_c: cover property (@(posedge clk) disable iff (reset) $rose(flag_r));
  flag_clr_c: cover property (@(posedge clk) disable iff (reset) flag_clr && flag_r ##1 !flag_r);
  move_c: cover property (@(posedge clk) disable iff (reset) port_wr && port_wr_is_move && mismatch);
  pullup_c: cover property (@(posedge clk) disable iff (reset) pullup_en != 8'h00);
  strap_c: cover property (@(posedge clk) $fell(reset) && !lower_pins_analog_default);
endmodule : ebpcp_port

// file: sim/ebpcp_pins.sv
`timescale 1ns/1ns
module ebpcp_pins (
  // clock
  input wire logic clk,
  // device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pullup_en,
  // outside drivers
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // resolved levels
  output logic [7:0] pin_in
);
  // ----------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------
  // undriven pins wander, so a missing pull-up cannot pass by luck
  logic [7:0] float_r = 8'h55;
  always @(posedge clk)
    float_r <= ~float_r;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!pin_oe_n[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_r[i];
    end
  end
endmodule : ebpcp_pins

// file: sim/ebpcp_port_test.sv
`timescale 1ns/1ns
module ebpcp_port_test;
  logic clk = 0, reset = 1, port_rd = 0, port_wr = 0, port_wr_is_move = 0, latch_wr = 0;
  logic dir_wr = 0, pullup_wr = 0, pullup_wdata = 0, analog_wr = 0, flag_clr = 0;
  logic [7:0] port_wdata = 0, dir_wdata = 0, ext_val = 0, ext_en = 8'hff;
  logic [4:0] analog_wdata = 0;
  logic strap_analog = 1, strap_cap = 0;
  logic [7:0] port_rdata, latch_rdata, direction_mask, pin_in, pin_out, pin_oe_n, pullup_en;
  logic [4:0] analog_sel;
  logic pullup_disable_n, port_change_flag, wake_req, capture_alt_in, capture_alt_sel;
  logic [7:0] d, l;
  int miscompares = 0, cmp_count = 0, seed = 32'hb861;
  always #25 clk = ~clk;
  ebpcp_port ebpcp_port_inst (.clk(clk), .reset(reset), .lower_pins_analog_default(strap_analog),
    .capture_pin_select(strap_cap), .port_rd(port_rd), .port_wr(port_wr), .port_wr_is_move(port_wr_is_move),
    .port_wdata(port_wdata), .port_rdata(port_rdata), .latch_wr(latch_wr), .latch_rdata(latch_rdata),
    .dir_wr(dir_wr), .dir_wdata(dir_wdata), .direction_mask(direction_mask), .pullup_wr(pullup_wr),
    .pullup_wdata(pullup_wdata), .pullup_disable_n(pullup_disable_n), .analog_wr(analog_wr),
    .analog_wdata(analog_wdata), .analog_sel(analog_sel), .flag_clr(flag_clr),
    .port_change_flag(port_change_flag), .wake_req(wake_req), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .capture_alt_in(capture_alt_in),
    .capture_alt_sel(capture_alt_sel));
  ebpcp_pins ebpcp_pins_inst (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // 0 read, 1 port write, 2 move, 3 latch, 4 dir, 5 pull-up, 6 analog, 7 flag clear
  task automatic op(input int k, input logic [7:0] v);
    @(negedge clk);
    {port_wdata, dir_wdata, pullup_wdata, analog_wdata} = {v, v, v[0], v[4:0]};
    case (k)
      0: port_rd = 1;
      1: port_wr = 1;
      2: {port_wr, port_wr_is_move} = 2'b11;
      3: latch_wr = 1;
      4: dir_wr = 1;
      5: pullup_wr = 1;
      6: analog_wr = 1;
      default: flag_clr = 1;
    endcase
    @(negedge clk);
    {port_rd, port_wr, port_wr_is_move, latch_wr, dir_wr, pullup_wr, analog_wr, flag_clr} = 8'h00;
  endtask : op
  task automatic wait_flag();
    int i;
    for (i = 0; i < 8 && port_change_flag !== 1'b1; i++)
      @(negedge clk);
    if (i == 8)
    begin
      miscompares++;
      print_verdict();
    end
  endtask : wait_flag
  function automatic logic [7:0] port_view(input logic [7:0] dm, input logic [7:0] lt, input logic [7:0] ev);
    return (dm & ev) | (~dm & lt);
  endfunction : port_view
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(negedge clk);
    reset = 0;
    repeat (2) @(negedge clk);
    chk(pin_oe_n, 8'hff);
    chk(pullup_en, 8'h00);
    chk({7'h00, pullup_disable_n}, 8'h01);
    chk({3'h0, analog_sel}, 8'h1f);
    chk({7'h00, capture_alt_sel}, 8'h01);
    repeat (3) @(negedge clk);
    chk(port_rdata & 8'h1f, 8'h00);
    op(6, 8'h00);
    for (int n = 0; n < 10; n++)
    begin
      d = 8'($random(seed));
      l = 8'($random(seed));
      ext_val = 8'($random(seed));
      ext_en = d;
      op(4, d);
      op(n[0] ? 3 : 1, l);
      op(5, {7'h00, n[1]});
      repeat (3) @(negedge clk);
      chk(pin_oe_n, d);
      chk(direction_mask, d);
      chk(pin_out, l);
      chk(latch_rdata, l);
      chk(pullup_en, n[1] ? 8'h00 : d);
      chk(port_rdata, port_view(d, l, ext_val));
      chk({7'h00, capture_alt_in}, {7'h00, pin_in[3]});
    end
    // upper two pins outputs; no polling of the port while detection runs
    ext_en = 8'h3f;
    ext_val = 8'h00;
    op(4, 8'h3f);
    op(1, 8'hc0);
    repeat (3) @(negedge clk);
    op(7, 8'h00);
    ext_val = 8'h0f;
    repeat (5) @(negedge clk);
    chk({7'h00, port_change_flag}, 8'h00);
    ext_val = 8'h1f;
    wait_flag();
    chk({7'h00, wake_req}, 8'h01);
    op(7, 8'h00);
    chk({7'h00, port_change_flag}, 8'h01);
    op(2, 8'hc0);
    op(7, 8'h00);
    chk({7'h00, port_change_flag}, 8'h01);
    op(1, 8'hc0);
    op(7, 8'h00);
    chk({7'h00, port_change_flag}, 8'h00);
    ext_val = 8'h2f;
    wait_flag();
    op(0, 8'h00);
    op(7, 8'h00);
    chk({6'h00, port_change_flag, wake_req}, 8'h00);
    // second reset with the other strap values
    ext_en = 8'hff;
    {reset, strap_analog, strap_cap} = 3'b101;
    repeat (2) @(negedge clk);
    reset = 0;
    repeat (2) @(negedge clk);
    chk({3'h0, analog_sel}, 8'h00);
    chk({7'h00, capture_alt_sel}, 8'h00);
    chk(pin_oe_n, 8'hff);
    repeat (3) @(negedge clk);
    chk(port_rdata & 8'h1f, ext_val & 8'h1f);
    print_verdict();
  end
endmodule : ebpcp_port_test
